// file: logic/qas_defines.vh
`ifndef QAS_DEFINES_VH
`define QAS_DEFINES_VH
// ------------------------------------------------------------
// clock and timing
// ------------------------------------------------------------
`define QAS_CLK_PS 10000
`define QAS_LOCK_NS 25000
`define QAS_LOCK_CYC ((`QAS_LOCK_NS * 1000) / `QAS_CLK_PS)
`define QAS_MIN_KSPS 5000
`define QAS_ENC_MAX_CYC (1000000000 / `QAS_MIN_KSPS / `QAS_CLK_PS)
`define QAS_ENC_STOP_CYC (2 * `QAS_ENC_MAX_CYC)
`define QAS_DCS_MIN_HI 2
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define QAS_OFS_CTRL 8'h00
`define QAS_OFS_STAT 8'h04
`define QAS_OFS_PERIOD 8'h08
// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define QAS_CTRL_ONE_LANE 0
`define QAS_CTRL_SER_LO 1
`define QAS_CTRL_SER_HI 2
`define QAS_CTRL_DCS_DIS 3
`define QAS_CTRL_RST 4'h0
`define QAS_SER_16 2'h0
`define QAS_SER_14 2'h1
`define QAS_SER_12 2'h2
// ------------------------------------------------------------
// status fields and fifo depth
// ------------------------------------------------------------
`define QAS_STAT_LOCKED 0
`define QAS_STAT_DCS_ON 1
`define QAS_STAT_OVF 2
`define QAS_STAT_PAR 3
`define QAS_STAT_BUSY 4
`define QAS_FIFO_DEPTH 8
`endif

// file: logic/qas_fifo.v
`timescale 1ns/1ps
module qas_fifo #(
  parameter WIDTH = 56,
  parameter DEPTH = 8
) (
  input wire hclk,
  input wire hresetn,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);
  localparam AW = $clog2(DEPTH);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_r;
  reg [AW-1:0] rd_r;
  reg [AW:0] cnt_r;
  wire push;
  wire pop;
  assign in_ready = (cnt_r != DEPTH[AW:0]);
  assign out_valid = (cnt_r != {(AW+1){1'b0}});
  assign out_data = mem[rd_r];
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // ----------------------------------------------------------
  // storage and pointers
  // ----------------------------------------------------------
  always @(posedge hclk) begin
    if (push) begin
      mem[wr_r] <= in_data;
    end
  end
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_r <= {AW{1'b0}};
      rd_r <= {AW{1'b0}};
      cnt_r <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_r <= (wr_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_r + 1'b1;
      end
      if (pop) begin
        rd_r <= (rd_r == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_r + 1'b1;
      end
      if (push && !pop) begin
        cnt_r <= cnt_r + 1'b1;
      end else if (pop && !push) begin
        cnt_r <= cnt_r - 1'b1;
      end
    end
  end
endmodule // qas_fifo

// file: logic/qas_top.v
// The AHB-Lite register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`include "qas_defines.vh"
module qas_top #(
  parameter NCH = 4,
  parameter DW = 14,
  parameter LOCK_CYC = `QAS_LOCK_CYC
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg [31:0] hrdata,
  output reg hreadyout,
  output reg hresp,
  input wire encode_clock_pos,
  input wire encode_clock_neg,
  input wire programming_mode_select,
  input wire [NCH*DW-1:0] sample_data,
  output reg forwarded_bit_clock,
  output reg frame_marker,
  output reg [NCH-1:0] lane_a,
  output reg [NCH-1:0] lane_b,
  output reg pll_locked
);
  localparam ST_IDLE = 1'b0;
  localparam ST_SHIFT = 1'b1;
  localparam WW = NCH * DW;
  // ----------------------------------------------------------
  // input synchronisers
  // ----------------------------------------------------------
  reg [2:0] pin_s1_r;
  reg [2:0] pin_s2_r;
  reg [WW-1:0] smp_s1_r;
  reg [WW-1:0] smp_s2_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pin_s1_r <= 3'h0;
      pin_s2_r <= 3'h0;
      smp_s1_r <= {WW{1'b0}};
      smp_s2_r <= {WW{1'b0}};
    end else begin
      pin_s1_r <= {programming_mode_select, encode_clock_neg, encode_clock_pos};
      pin_s2_r <= pin_s1_r;
      smp_s1_r <= sample_data;
      smp_s2_r <= smp_s1_r;
    end
  end
  wire par_mode = pin_s2_r[2];
  wire enc_lvl = pin_s2_r[0] & ~pin_s2_r[1];
  // ----------------------------------------------------------
  // registers
  // ----------------------------------------------------------
  reg [3:0] ctrl_r;
  reg ovf_r;
  reg [15:0] period_r;
  reg wr_pend_r;
  reg [7:0] wr_addr_r;
  wire dcs_on = par_mode | ~ctrl_r[`QAS_CTRL_DCS_DIS];
  wire acc = hsel & htrans[1] & hready;
  reg busy_r;
  reg locked_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_r <= 1'b0;
      wr_addr_r <= 8'h00;
      hrdata <= 32'h0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      wr_pend_r <= acc & hwrite;
      wr_addr_r <= haddr[7:0];
      hrdata <= 32'h0;
      if (acc && !hwrite && haddr[31:8] == 24'h0) begin
        case (haddr[7:0])
          `QAS_OFS_CTRL: hrdata <= {28'h0, ctrl_r};
          `QAS_OFS_STAT: hrdata <= {27'h0, busy_r, par_mode, ovf_r, dcs_on, locked_r};
          `QAS_OFS_PERIOD: hrdata <= {16'h0, period_r};
          default: hrdata <= 32'h0;
        endcase
      end
    end
  end
  wire wr_ctrl = wr_pend_r && wr_addr_r == `QAS_OFS_CTRL;
  wire clr_ovf = wr_pend_r && wr_addr_r == `QAS_OFS_STAT && hwdata[`QAS_STAT_OVF];
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctrl_r <= `QAS_CTRL_RST;
    end else if (wr_ctrl) begin
      ctrl_r <= hwdata[3:0];
    end
  end
  // ----------------------------------------------------------
  // encode edge, period and lock
  // ----------------------------------------------------------
  reg enc_d_r;
  reg [15:0] per_cnt_r;
  reg [7:0] hi_cnt_r;
  reg [12:0] lock_cnt_r;
  reg stopped_r;
  wire enc_rise = enc_lvl & ~enc_d_r;
  wire hi_ok = hi_cnt_r >= `QAS_DCS_MIN_HI;
  wire conv = enc_rise & (dcs_on | hi_ok);
  wire [15:0] per_diff = (per_cnt_r > period_r) ? per_cnt_r - period_r : period_r - per_cnt_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      enc_d_r <= 1'b0;
      per_cnt_r <= 16'h0;
      hi_cnt_r <= 8'h0;
      period_r <= 16'h0;
      stopped_r <= 1'b1;
      lock_cnt_r <= 13'h0;
      locked_r <= 1'b0;
      pll_locked <= 1'b0;
    end else begin
      enc_d_r <= enc_lvl;
      if (enc_lvl && !enc_d_r) begin
        hi_cnt_r <= 8'h1;
      end else if (enc_lvl && hi_cnt_r != 8'hff) begin
        hi_cnt_r <= hi_cnt_r + 8'h1;
      end
      if (conv) begin
        per_cnt_r <= 16'h1;
        period_r <= per_cnt_r;
        stopped_r <= 1'b0;
        if (stopped_r || per_diff > 16'h1) begin
          lock_cnt_r <= LOCK_CYC[12:0];
        end else if (lock_cnt_r != 13'h0) begin
          lock_cnt_r <= lock_cnt_r - 13'h1;
        end
      end else begin
        if (per_cnt_r != 16'hffff) begin
          per_cnt_r <= per_cnt_r + 16'h1;
        end
        if (per_cnt_r >= `QAS_ENC_STOP_CYC) begin
          stopped_r <= 1'b1;
        end
        if (lock_cnt_r != 13'h0) begin
          lock_cnt_r <= lock_cnt_r - 13'h1;
        end
      end
      locked_r <= ~stopped_r & (lock_cnt_r == 13'h0);
      pll_locked <= ~stopped_r & (lock_cnt_r == 13'h0);
    end
  end
  // ----------------------------------------------------------
  // sample fifo
  // ----------------------------------------------------------
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [WW-1:0] fifo_out_data;
  wire load;
  qas_fifo #(.WIDTH(WW), .DEPTH(`QAS_FIFO_DEPTH)) u_fifo (
    .hclk(hclk),
    .hresetn(hresetn),
    .in_valid(conv),
    .in_ready(fifo_in_ready),
    .in_data(smp_s2_r),
    .out_valid(fifo_out_valid),
    .out_ready(load),
    .out_data(fifo_out_data)
  );
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ovf_r <= 1'b0;
    end else if (conv && !fifo_in_ready) begin
      ovf_r <= 1'b1;
    end else if (clr_ovf) begin
      ovf_r <= 1'b0;
    end
  end
  // ----------------------------------------------------------
  // serializer
  // ----------------------------------------------------------
  reg ph_r;
  reg state_r;
  reg [4:0] slot_r;
  reg one_lane_r;
  reg [1:0] ser_r;
  wire [1:0] ser_in = ctrl_r[`QAS_CTRL_SER_HI:`QAS_CTRL_SER_LO];
  wire one_in = par_mode ? 1'b0 : ctrl_r[`QAS_CTRL_ONE_LANE];
  wire tick = ~ph_r;
  reg [4:0] nslot;
  always @* begin
    case (ser_r)
      `QAS_SER_14: nslot = 5'd14;
      `QAS_SER_12: nslot = 5'd12;
      default: nslot = 5'd16;
    endcase
    if (!one_lane_r) begin
      nslot = {1'b0, nslot[4:1]};
    end
  end
  wire last = (state_r == ST_SHIFT) && (slot_r == nslot - 5'd1);
  assign load = tick && fifo_out_valid && (state_r == ST_IDLE || last);
  wire half_in = (ser_in == `QAS_SER_14) && !one_in;
  wire half_cur = (ser_r == `QAS_SER_14) && !one_lane_r;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ph_r <= 1'b0;
      forwarded_bit_clock <= 1'b0;
      state_r <= ST_IDLE;
      slot_r <= 5'h0;
      one_lane_r <= 1'b0;
      ser_r <= `QAS_SER_16;
      frame_marker <= 1'b0;
      busy_r <= 1'b0;
    end else begin
      ph_r <= ~ph_r;
      if (ph_r) begin
        forwarded_bit_clock <= ~forwarded_bit_clock;
      end
      busy_r <= (state_r == ST_SHIFT);
      if (tick) begin
        case (state_r)
          ST_IDLE: begin
            if (load) begin
              state_r <= ST_SHIFT;
              slot_r <= 5'h0;
              one_lane_r <= one_in;
              ser_r <= ser_in;
              frame_marker <= half_in ? ~frame_marker : 1'b1;
            end else if (!half_cur) begin
              frame_marker <= 1'b0;
            end
          end
          ST_SHIFT: begin
            if (load) begin
              slot_r <= 5'h0;
              one_lane_r <= one_in;
              ser_r <= ser_in;
              frame_marker <= half_in ? ~frame_marker : 1'b1;
            end else if (last) begin
              state_r <= ST_IDLE;
              if (!half_cur) begin
                frame_marker <= 1'b0;
              end
            end else begin
              slot_r <= slot_r + 5'd1;
              if (!half_cur) begin
                frame_marker <= (slot_r + 5'd1) < {1'b0, nslot[4:1]};
              end
            end
          end
          default: state_r <= ST_IDLE;
        endcase
      end
    end
  end
  wire unused_ok = |hsize;
  // ----------------------------------------------------------
  // per-channel shift registers
  // ----------------------------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c = c + 1) begin : g_ch
      reg [15:0] sh_r;
      wire [DW-1:0] d = fifo_out_data[c*DW +: DW];
      wire [15:0] wd = (ser_in == `QAS_SER_12) ? {d[DW-1:2], 4'h0} : {d, 2'b00};
      always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
          sh_r <= 16'h0;
          lane_a[c] <= 1'b0;
          lane_b[c] <= 1'b0;
        end else if (tick) begin
          if (load) begin
            lane_a[c] <= wd[15];
            lane_b[c] <= one_in ? 1'b0 : wd[14];
            sh_r <= one_in ? {wd[14:0], 1'b0} : {wd[13:0], 2'b00};
          end else if (state_r == ST_SHIFT && !last) begin
            lane_a[c] <= sh_r[15];
            lane_b[c] <= one_lane_r ? 1'b0 : sh_r[14];
            sh_r <= one_lane_r ? {sh_r[14:0], 1'b0} : {sh_r[13:0], 2'b00};
          end else if (last) begin
            lane_a[c] <= 1'b0;
            lane_b[c] <= 1'b0;
          end
        end
      end
    end
  endgenerate
endmodule // qas_top

// file: testbench/qas_checker.sv
`timescale 1ns/1ps
// ----------------------------------------
// port checker
// ----------------------------------------
module qas_checker #(
  parameter NCH = 4,
  parameter LOCK_CYC = 20
) (
  input wire hclk,
  input wire hresetn,
  input wire hsel,
  input wire [31:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [31:0] hwdata,
  input wire hready,
  input wire [31:0] hrdata,
  input wire hreadyout,
  input wire hresp,
  input wire encode_clock_pos,
  input wire programming_mode_select,
  input wire forwarded_bit_clock,
  input wire frame_marker,
  input wire [NCH-1:0] lane_a,
  input wire [NCH-1:0] lane_b,
  input wire pll_locked
);
  logic acc;
  logic wr_p_r, rd_p_r, one_lane_r;
  logic [7:0] age_r, idle_r;
  assign acc = hsel && htrans[1] && hready;
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_p_r <= 1'b0;
      rd_p_r <= 1'b0;
      one_lane_r <= 1'b0;
      age_r <= 8'h00;
      idle_r <= 8'h00;
    end else begin
      wr_p_r <= acc && hwrite && haddr[7:0] == 8'h00;
      rd_p_r <= acc && !hwrite;
      if ($changed(encode_clock_pos)) idle_r <= 8'h00;
      else if (idle_r != 8'hff) idle_r <= idle_r + 8'h01;
      if (wr_p_r) begin
        one_lane_r <= hwdata[0];
        age_r <= 8'h00;
      end else if (age_r != 8'hff) age_r <= age_r + 8'h01;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  sequence s_mid_bit; $stable(lane_a) && $changed(forwarded_bit_clock); endsequence
  sequence s_next_tick; $stable(forwarded_bit_clock) ##1 $changed(forwarded_bit_clock); endsequence
  property p_okay; hresp == 1'b0 && hreadyout == 1'b1; endproperty
  property p_rdata; !rd_p_r |-> hrdata == 32'h0; endproperty
  property p_bclk; $changed(forwarded_bit_clock) |=> s_next_tick; endproperty
  property p_a_hold; $changed(lane_a) |-> $stable(forwarded_bit_clock) ##1 s_mid_bit; endproperty
  property p_b_hold; $changed(lane_b) |=> $stable(lane_b); endproperty
  property p_one_lane;
    one_lane_r && !programming_mode_select && age_r == 8'hff |-> lane_b == '0;
  endproperty
  property p_frame; $changed(frame_marker) |-> $stable(forwarded_bit_clock); endproperty
  property p_stop; idle_r > 8'd60 |-> !pll_locked; endproperty
  a_okay: assert property (p_okay) else $error("bad bus answer");
  a_rdata: assert property (p_rdata) else $error("read data held");
  a_bclk: assert property (p_bclk) else $error("bit clock rate");
  a_a_hold: assert property (p_a_hold) else $error("lane a timing");
  a_b_hold: assert property (p_b_hold) else $error("lane b timing");
  a_one_lane: assert property (p_one_lane) else $error("lane b used");
  a_frame: assert property (p_frame) else $error("frame timing");
  a_stop: assert property (p_stop) else $error("lock kept");
endmodule // qas_checker
bind qas_top qas_checker #(.NCH(NCH), .LOCK_CYC(LOCK_CYC)) qas_checker_inst (
  .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .encode_clock_pos(encode_clock_pos),
  .programming_mode_select(programming_mode_select),
  .forwarded_bit_clock(forwarded_bit_clock), .frame_marker(frame_marker),
  .lane_a(lane_a), .lane_b(lane_b), .pll_locked(pll_locked));

// file: testbench/qas_rx_model.sv
`timescale 1ns/1ps
// ----------------------------------------
// receiver model
// ----------------------------------------
module qas_rx_model (
  input wire forwarded_bit_clock,
  input wire frame_marker,
  input wire [3:0] lane_a,
  input wire [3:0] lane_b,
  input wire pll_locked,
  input wire one_lane,
  input wire [1:0] ser,
  output logic [3:0][15:0] word,
  output int words_seen
);
  logic prev_r = 1'b0;
  logic [15:0] sh [4];
  int cnt = 0;
  int nb;
  initial words_seen = 0;
  always @(forwarded_bit_clock) begin
    nb = 16 - 2 * ser;
    if (pll_locked) begin
      if ((frame_marker && !prev_r) || (!one_lane && nb == 14 && frame_marker != prev_r)) begin
        cnt = 0;
      end
      for (int c = 0; c < 4; c++) begin
        sh[c] = one_lane ? {sh[c][14:0], lane_a[c]} : {sh[c][13:0], lane_a[c], lane_b[c]};
      end
      cnt += one_lane ? 1 : 2;
      if (cnt == nb) begin
        for (int c = 0; c < 4; c++) word[c] = sh[c] << (16 - nb);
        words_seen++;
      end
    end
    prev_r = frame_marker;
  end
endmodule // qas_rx_model

// file: testbench/quad_adc_serial_output_bench.sv
`timescale 1ns/1ps
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin fail_count++; \
  $display("Error at %0t: got %h expected %h", $time, a, e); end end
// ----------------------------------------
// bench top
// ----------------------------------------
module quad_adc_serial_output_bench;
  logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, enc_on = 0, one_lane = 0;
  logic encode_clock_pos = 0, programming_mode_select = 0;
  logic [1:0] htrans = 2'h0, ser = 2'h0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, rd;
  logic [55:0] sample_data = 56'h0;
  logic [13:0] d;
  logic [15:0] exp_w;
  logic [3:0][15:0] word;
  wire hreadyout, hresp, forwarded_bit_clock, frame_marker, pll_locked;
  wire [3:0] lane_a, lane_b;
  wire [31:0] hrdata;
  wire hready = hreadyout;
  int words_seen, t, nbits, half;
  int fail_count = 0, samples_checked = 0;
  qas_top #(.LOCK_CYC(20)) qas_top_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .encode_clock_pos(encode_clock_pos), .encode_clock_neg(1'b0),
    .programming_mode_select(programming_mode_select), .sample_data(sample_data),
    .forwarded_bit_clock(forwarded_bit_clock), .frame_marker(frame_marker),
    .lane_a(lane_a), .lane_b(lane_b), .pll_locked(pll_locked));
  qas_rx_model qas_rx_model_inst (.forwarded_bit_clock(forwarded_bit_clock),
    .frame_marker(frame_marker), .lane_a(lane_a), .lane_b(lane_b),
    .pll_locked(pll_locked), .one_lane(one_lane), .ser(ser), .word(word),
    .words_seen(words_seen));
  initial forever #5 hclk = ~hclk;
  initial forever begin
    repeat (4) @(posedge hclk);
    encode_clock_pos <= enc_on & ~encode_clock_pos;
  end
  function automatic logic [13:0] dval(input int c, input int m);
    return 14'h2a5c ^ 14'(c * 273 + m * 4);
  endfunction
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    int n;
    n = 0;
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100) begin n++; @(posedge hclk); end
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge hclk);
    while (hready !== 1'b1 && n < 100) begin n++; @(posedge hclk); end
    rd = hrdata;
    if (n >= 100) fail_count++;
  endtask
  task automatic wait_until(input int which);
    logic f0;
    int n0;
    f0 = frame_marker;
    n0 = words_seen;
    t = 0;
    while (t < 2000 && (which == 0 ? pll_locked !== 1'b1 :
           which == 1 ? words_seen == n0 : frame_marker === f0)) begin
      t++;
      @(posedge hclk);
    end
    if (t >= 2000) fail_count++;
  endtask
  task automatic close_out;
    $display("compares %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    #300000;
    fail_count++;
    close_out;
  end
  initial begin
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h0)
    xfer(1'b0, 8'h04, 32'h0); `CHK(rd, 32'h2)
    xfer(1'b0, 8'h0c, 32'h0); `CHK(rd, 32'h0)
    enc_on <= 1'b1;
    wait_until(0); `CHK(pll_locked, 1'b1)
    xfer(1'b0, 8'h08, 32'h0); `CHK(rd, 32'h8)
    $display("reset and lock test done");
    for (int m = 0; m < 6; m++) begin
      one_lane = (m >= 3);
      ser = 2'(m % 3);
      nbits = 16 - 2 * (m % 3);
      for (int c = 0; c < 4; c++) sample_data[c*14 +: 14] <= dval(c, m);
      xfer(1'b1, 8'h00, {29'h0, ser, one_lane});
      repeat (400) @(posedge hclk);
      wait_until(1);
      for (int c = 0; c < 4; c++) begin
        d = dval(c, m);
        exp_w = (ser == 2'h2) ? {d[13:2], 4'h0} : {d, 2'h0};
        `CHK(word[c], exp_w)
      end
      half = one_lane ? nbits : (nbits == 14 ? 14 : nbits / 2);
      wait_until(2);
      wait_until(2); `CHK(t, half)
      $display("mode %0d done", m);
    end
    xfer(1'b0, 8'h04, 32'h0); `CHK(rd[4:0], 5'h17)
    enc_on <= 1'b0;
    repeat (600) @(posedge hclk);
    xfer(1'b0, 8'h04, 32'h0); `CHK(rd[4:0], 5'h06)
    xfer(1'b1, 8'h04, 32'h4);
    xfer(1'b0, 8'h04, 32'h0); `CHK(rd[4:0], 5'h02)
    enc_on <= 1'b1;
    repeat (20) @(posedge hclk);
    `CHK(pll_locked, 1'b0)
    wait_until(0); `CHK(pll_locked, 1'b1)
    $display("overflow and relock test done");
    xfer(1'b1, 8'h00, 32'h8);
    xfer(1'b0, 8'h04, 32'h0); `CHK(rd[1], 1'b0)
    hresetn <= 1'b0;
    programming_mode_select <= 1'b1;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    xfer(1'b1, 8'h00, 32'h8);
    xfer(1'b0, 8'h00, 32'h0); `CHK(rd, 32'h8)
    xfer(1'b0, 8'h04, 32'h0); `CHK({rd[3], rd[1]}, 2'h3)
    $display("stabilizer test done");
    close_out;
  end
endmodule // quad_adc_serial_output_bench
